// ===== inc/lces_pkg.sv
// Constants for the per-lane invalid code and stray control character status block
// How it works
// - Read-only 8-bit invalid code status register; bit n shows lane n, lanes 0 to 7.
// - Status bit reads 1 when the lane's error count is at or above threshold.
// - Status bit reads 0 while the lane's error count stays below threshold.
// - Read-only 8-bit stray control character register; bit n flags lane n at threshold.
// - All status bits reset to 0; software writes never change them.
// - Bit 0 of the stray control register reports lane 0 against the threshold.
package lces_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFF_INVALID_CODE_STATUS = 12'h46E;
  localparam logic [ADDR_W-1:0] OFF_STRAY_CONTROL_STATUS = 12'h46F;
  localparam logic [DATA_W-1:0] RST_STATUS = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

  // ************************************************************
  // Lanes and counters
  // ************************************************************
  localparam int NUM_LANES = 8;
  localparam int CNT_W = 8;

  typedef enum logic [1:0] {
    LCES_SEL_NONE = 2'h0,
    LCES_SEL_INVALID = 2'h1,
    LCES_SEL_STRAY = 2'h3
  } lces_sel_e;

endpackage

// ===== tb/lane_code_error_status_tb.sv
// Self-checking bench for the lane code error status block
`timescale 1ns/1ns
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp); end end
module lane_code_error_status_tb;
  import lces_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic slow = 1'b0;
  logic clear_counts = 1'b0;
  logic reg_rd_en = 1'b0;
  logic reg_wr_en = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wr_data = 8'h00;
  logic [7:0] error_threshold = 8'h01;
  logic [7:0] inv_mask = 8'h00;
  logic [7:0] stray_mask = 8'h00;
  logic [7:0] invalid_code_event, stray_control_event, reg_rd_data;
  logic [7:0] invalid_code_flags, stray_control_flags;
  logic reg_rd_valid, reg_wr_refused;
  int num_errors = 0;
  int total_checks = 0;
  int op;
  int cnt_inv [8] = '{default: 0};
  int cnt_stray [8] = '{default: 0};
  logic [7:0] exp_inv = 8'h00;
  logic [7:0] exp_stray = 8'h00;
  logic [7:0] exp_rdata = 8'h00;
  logic exp_vld = 1'b0;
  logic exp_ref = 1'b0;

  always #5 clock = ~clock;

  lces_top dut (.clock, .srst, .invalid_code_event, .stray_control_event, .error_threshold,
    .clear_counts, .reg_rd_en, .reg_wr_en, .reg_addr, .reg_wr_data, .reg_rd_data,
    .reg_rd_valid, .reg_wr_refused, .invalid_code_flags, .stray_control_flags);
  lces_link_model link (.clock, .slow, .inv_mask, .stray_mask, .invalid_code_event,
    .stray_control_event);

  function automatic int sat_next(int c, logic ev);
    return (srst || clear_counts) ? 0 : ((c == 255) ? 255 : c + int'(ev));
  endfunction

  // ************************************************************
  // Reference model and checks
  // ************************************************************
  always @(posedge clock) begin
    for (int n = 0; n < 8; n++) begin
      cnt_inv[n] = sat_next(cnt_inv[n], invalid_code_event[n]);
      cnt_stray[n] = sat_next(cnt_stray[n], stray_control_event[n]);
      exp_inv[n] <= !srst && (cnt_inv[n] >= error_threshold);
      exp_stray[n] <= !srst && (cnt_stray[n] >= error_threshold);
    end
    exp_vld <= !srst && reg_rd_en;
    exp_ref <= !srst && reg_wr_en &&
      (reg_addr == OFF_INVALID_CODE_STATUS || reg_addr == OFF_STRAY_CONTROL_STATUS);
    if (srst) begin
      exp_rdata <= RST_STATUS;
    end else if (reg_rd_en) begin
      exp_rdata <= (reg_addr == OFF_INVALID_CODE_STATUS) ? exp_inv :
        (reg_addr == OFF_STRAY_CONTROL_STATUS) ? exp_stray : UNMAPPED_READ;
    end
  end

  always @(negedge clock) begin
    `CHK(invalid_code_flags, exp_inv)
    `CHK(stray_control_flags, exp_stray)
    `CHK(reg_rd_data, exp_rdata)
    `CHK(reg_rd_valid, exp_vld)
    `CHK(reg_wr_refused, exp_ref)
  end

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10000) @(posedge clock);
    num_errors++;
    summarize();
  end

  initial begin
    void'($urandom(29));
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    error_threshold <= 8'h00;
    repeat (4) @(posedge clock);
    // Top threshold plus a long burst: a wrapping counter would drop its flag
    error_threshold <= 8'hFF;
    inv_mask <= 8'hFF;
    stray_mask <= 8'hA5;
    repeat (300) @(posedge clock);
    clear_counts <= 1'b1;
    @(posedge clock);
    clear_counts <= 1'b0;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clock);
      op = $urandom_range(0, 5);
      inv_mask <= 8'($urandom & $urandom & $urandom);
      stray_mask <= 8'($urandom & $urandom & $urandom);
      slow <= i[9];
      srst <= (i >= 1500 && i < 1503);
      clear_counts <= ($urandom_range(0, 149) == 0);
      if (i % 200 == 0) begin
        error_threshold <= 8'($urandom_range(0, 12));
      end
      reg_rd_en <= (op < 3);
      reg_wr_en <= (op == 3 || op == 4);
      reg_wr_data <= 8'($urandom);
      reg_addr <= (op % 3 == 2) ? 12'($urandom) :
        (op[0] ? OFF_STRAY_CONTROL_STATUS : OFF_INVALID_CODE_STATUS);
    end
    repeat (4) @(posedge clock);
    summarize();
  end
endmodule

// ===== tb/lces_link_model.sv
// Link-side stand-in that raises per-lane code error events
`timescale 1ns/1ns
module lces_link_model (
  input wire logic clock,
  input wire logic slow,
  input wire logic [7:0] inv_mask,
  input wire logic [7:0] stray_mask,
  output logic [7:0] invalid_code_event,
  output logic [7:0] stray_control_event
);
  logic phase_q = 1'b0;
  initial begin
    invalid_code_event = 8'h00;
    stray_control_event = 8'h00;
  end
  // A slow link flags errors only on every other character slot
  always @(posedge clock) begin
    phase_q <= ~phase_q;
    invalid_code_event <= (slow && phase_q) ? 8'h00 : inv_mask;
    stray_control_event <= (slow && phase_q) ? 8'h00 : stray_mask;
  end
endmodule

// ===== verilog/lces_lane_counter.sv
// Saturating error counter for one lane and one error type, with threshold flag
`timescale 1ns/1ns
module lces_lane_counter #(
  parameter int CNT_W = 8
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic clear_counts,
  input wire logic error_event,
  input wire logic [CNT_W-1:0] error_threshold,
  output logic [CNT_W-1:0] error_count,
  output logic threshold_flag
);
  import lces_pkg::*;

  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  localparam logic [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic flag_q;
  logic flag_d;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    count_d = count_q;
    if (clear_counts) begin
      count_d = CNT_ZERO;
    end else if (error_event && (count_q != CNT_MAX)) begin
      // Holding at full scale keeps a burst from wrapping the flag back to 0
      count_d = count_q + 1'b1;
    end
    flag_d = (count_d >= error_threshold);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      count_q <= CNT_ZERO;
      flag_q <= 1'b0;
    end else begin
      count_q <= count_d;
      flag_q <= flag_d;
    end
  end

  assign error_count = count_q;
  assign threshold_flag = flag_q;

endmodule

// ===== verilog/lces_top.sv
// Per-lane invalid code and stray control character status with register read port
`timescale 1ns/1ns
module lces_top #(
  parameter int NUM_LANES = lces_pkg::NUM_LANES,
  parameter int CNT_W = lces_pkg::CNT_W
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [NUM_LANES-1:0] invalid_code_event,
  input wire logic [NUM_LANES-1:0] stray_control_event,
  input wire logic [CNT_W-1:0] error_threshold,
  input wire logic clear_counts,
  input wire logic reg_rd_en,
  input wire logic reg_wr_en,
  input wire logic [lces_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lces_pkg::DATA_W-1:0] reg_wr_data,
  output logic [lces_pkg::DATA_W-1:0] reg_rd_data,
  output logic reg_rd_valid,
  output logic reg_wr_refused,
  output logic [NUM_LANES-1:0] invalid_code_flags,
  output logic [NUM_LANES-1:0] stray_control_flags
);
  import lces_pkg::*;

  // ************************************************************
  // Address decode
  // ************************************************************
  function automatic lces_sel_e decode_addr(input logic [ADDR_W-1:0] addr);
    lces_sel_e sel;
    sel = LCES_SEL_NONE;
    if (addr == OFF_INVALID_CODE_STATUS) begin
      sel = LCES_SEL_INVALID;
    end else if (addr == OFF_STRAY_CONTROL_STATUS) begin
      sel = LCES_SEL_STRAY;
    end
    return sel;
  endfunction

  logic [CNT_W-1:0] invalid_count [NUM_LANES];
  logic [CNT_W-1:0] stray_count [NUM_LANES];
  logic [NUM_LANES-1:0] invalid_flag;
  logic [NUM_LANES-1:0] stray_flag;

  // ************************************************************
  // Per-lane counters
  // ************************************************************
  for (genvar n = 0; n < NUM_LANES; n++) begin : g_lane
    // Bit n of each status register is lane n
    lces_lane_counter #(
      .CNT_W(CNT_W)
    ) u_invalid (
      .clock(clock),
      .srst(srst),
      .clear_counts(clear_counts),
      .error_event(invalid_code_event[n]),
      .error_threshold(error_threshold),
      .error_count(invalid_count[n]),
      .threshold_flag(invalid_flag[n])
    );

    lces_lane_counter #(
      .CNT_W(CNT_W)
    ) u_stray (
      .clock(clock),
      .srst(srst),
      .clear_counts(clear_counts),
      .error_event(stray_control_event[n]),
      .error_threshold(error_threshold),
      .error_count(stray_count[n]),
      .threshold_flag(stray_flag[n])
    );

    a_invalid_flag_set: assert property (@(posedge clock) disable iff (srst)
      (!$past(srst) && !$past(clear_counts) && (invalid_count[n] >= $past(error_threshold)))
      |-> invalid_flag[n])
      else $error("invalid code flag low at or above threshold");

    a_invalid_flag_clr: assert property (@(posedge clock) disable iff (srst)
      (!$past(srst) && (invalid_count[n] < $past(error_threshold)))
      |-> !invalid_flag[n])
      else $error("invalid code flag high below threshold");

    a_stray_flag_lane: assert property (@(posedge clock) disable iff (srst)
      !$past(srst) |-> (stray_flag[n] == (stray_count[n] >= $past(error_threshold))))
      else $error("stray control flag disagrees with count and threshold");

    a_count_saturates: assert property (@(posedge clock) disable iff (srst)
      (invalid_count[n] == {CNT_W{1'b1}}) && invalid_code_event[n] && !clear_counts
      |=> invalid_count[n] == {CNT_W{1'b1}})
      else $error("invalid code counter wrapped");

    a_count_steps: assert property (@(posedge clock) disable iff (srst)
      (stray_count[n] != {CNT_W{1'b1}}) && stray_control_event[n] && !clear_counts
      |=> stray_count[n] == $past(stray_count[n]) + 1'b1)
      else $error("stray control counter missed an event");
  end

  // ************************************************************
  // Register read port
  // ************************************************************
  logic [DATA_W-1:0] rd_data_q;
  logic [DATA_W-1:0] rd_data_d;
  logic rd_valid_q;
  logic rd_valid_d;
  logic wr_refused_q;
  logic wr_refused_d;
  logic [NUM_LANES-1:0] invalid_stat;
  logic [NUM_LANES-1:0] stray_stat;

  assign invalid_stat = invalid_flag;
  assign stray_stat = stray_flag;

  always_comb begin
    rd_data_d = rd_data_q;
    rd_valid_d = reg_rd_en;
    // Both status registers are read-only, so any write to them is dropped and reported
    wr_refused_d = reg_wr_en && (decode_addr(reg_addr) != LCES_SEL_NONE);
    if (reg_rd_en) begin
      case (decode_addr(reg_addr))
        LCES_SEL_INVALID: begin
          rd_data_d = DATA_W'(invalid_stat);
        end
        LCES_SEL_STRAY: begin
          rd_data_d = DATA_W'(stray_stat);
        end
        default: begin
          rd_data_d = UNMAPPED_READ;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rd_data_q <= RST_STATUS;
      rd_valid_q <= 1'b0;
      wr_refused_q <= 1'b0;
    end else begin
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      wr_refused_q <= wr_refused_d;
    end
  end

  assign reg_rd_data = rd_data_q;
  assign reg_rd_valid = rd_valid_q;
  assign reg_wr_refused = wr_refused_q;
  assign invalid_code_flags = invalid_flag;
  assign stray_control_flags = stray_flag;

  // ************************************************************
  // Checks
  // ************************************************************
  a_read_invalid: assert property (@(posedge clock) disable iff (srst)
    reg_rd_en && (reg_addr == OFF_INVALID_CODE_STATUS)
    |=> reg_rd_valid && (reg_rd_data == DATA_W'($past(invalid_flag))))
    else $error("invalid code status read returned wrong data");

  a_read_stray: assert property (@(posedge clock) disable iff (srst)
    reg_rd_en && (reg_addr == OFF_STRAY_CONTROL_STATUS)
    |=> reg_rd_valid && (reg_rd_data == DATA_W'($past(stray_flag))))
    else $error("stray control status read returned wrong data");

  a_reset_clears: assert property (@(posedge clock)
    srst |=> (invalid_flag == '0) && (stray_flag == '0) && !reg_rd_valid)
    else $error("status bits not cleared by reset");

  a_write_ignored: assert property (@(posedge clock) disable iff (srst)
    !$past(srst) && reg_wr_en && !reg_rd_en && (reg_addr == OFF_INVALID_CODE_STATUS)
    && (reg_wr_data != RST_STATUS) && (invalid_code_event == '0) && !clear_counts
    && (error_threshold == $past(error_threshold))
    |=> reg_wr_refused && (invalid_flag == $past(invalid_flag)))
    else $error("write changed a read-only status bit");

endmodule
